// file: common/odpsr_consts.svh
/*
  constants for the output driver power and short-circuit register bank:
  offsets, field positions, reset values.
  assumes inclusion by bare name from the design files.
*/
`ifndef ODPSR_CONSTS_SVH
`define ODPSR_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ODPSR_OFS_PAGE 8'h00
`define ODPSR_OFS_RSVD_LO 8'h01
`define ODPSR_OFS_RSVD_HI 8'h1d
`define ODPSR_OFS_AMP_ERR 8'h1e
`define ODPSR_OFS_HP_DRV 8'h1f
`define ODPSR_OFS_SPK_DRV 8'h20
`define ODPSR_DRIVER_PAGE 8'h01
// ----------------------------------------
// field positions
// ----------------------------------------
`define ODPSR_BIT_LEFT_PWR 7
`define ODPSR_BIT_RIGHT_PWR 6
`define ODPSR_BIT_HP_RSVD0 5
`define ODPSR_CM_HI 4
`define ODPSR_CM_LO 3
`define ODPSR_BIT_HP_RSVD1 2
`define ODPSR_BIT_HP_ACTION 1
`define ODPSR_BIT_STATUS 0
`define ODPSR_BIT_SPK_POLICY 1
`define ODPSR_BIT_HP_POLICY 0
`define ODPSR_SPK_RSVD_HI 5
`define ODPSR_SPK_RSVD_LO 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define ODPSR_RST_PAGE 8'h00
`define ODPSR_RST_AMP_ERR 8'h00
`define ODPSR_RST_HP_DRV 8'h04
`define ODPSR_RST_SPK_DRV 8'h06
`define ODPSR_RST_RSVD 8'h00
`define ODPSR_RST_RDATA 8'h00
`endif

// file: common/odpsr_pkg.sv
/*
  types for the output driver power and short-circuit register bank.
  assumes odpsr_consts.svh on the include path.
*/
`default_nettype none
package odpsr_pkg;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {ODPSR_CM_1V35, ODPSR_CM_1V5, ODPSR_CM_1V65, ODPSR_CM_1V8} odpsr_cm_t;
  typedef struct packed {
    logic left_on;
    logic right_on;
  } odpsr_pair_t;
  // one register access as seen by the bank
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } odpsr_req_t;
  // driver-facing controls
  typedef struct packed {
    odpsr_pair_t hp_pwr;
    odpsr_pair_t spk_pwr;
    odpsr_cm_t hp_cm;
    logic hp_limit;
    logic hp_force_off;
  } odpsr_drv_t;
endpackage : odpsr_pkg
`default_nettype wire

// file: rtl/odpsr_fault_ctl.sv
/*
  short-circuit policy: decides current limiting, forced power-down
  and which power-up bits must clear on a detected short.
  assumes short inputs are synchronous to ref_clk.
*/
`include "odpsr_consts.svh"
`default_nettype none
module odpsr_fault_ctl
  import odpsr_pkg::*;
(
  // detector levels
  input wire logic hp_short,
  input wire logic spk_short,
  // policy bits
  input wire logic hp_action_pd,
  input wire logic hp_keep,
  input wire logic spk_keep,
  // results
  output logic hp_limit,
  output logic hp_force_off,
  output logic hp_clear,
  output logic spk_clear
);
  // ----------------------------------------
  // policy
  // ----------------------------------------
  // limit while action bit low, power off while high
  assign hp_limit = hp_short & ~hp_action_pd;
  assign hp_force_off = hp_short & hp_action_pd;
  // headphone self-clears only with power-down action and no keep; speaker self-clears on no keep alone
  assign hp_clear = hp_short & hp_action_pd & ~hp_keep;
  assign spk_clear = spk_short & ~spk_keep;
endmodule : odpsr_fault_ctl
`default_nettype wire

// file: rtl/odpsr_rd_mux.sv
/*
  read multiplexer of the register bank.
  assumes register images already assembled by the caller.
*/
`include "odpsr_consts.svh"
`default_nettype none
module odpsr_rd_mux
  import odpsr_pkg::*;
(
  // access
  input wire logic [7:0] addr,
  input wire logic on_page,
  // images
  input wire logic [7:0] page_img,
  input wire logic [7:0] amp_img,
  input wire logic [7:0] hp_img,
  input wire logic [7:0] spk_img,
  input wire logic [7:0] rsvd_img,
  // result
  output logic [7:0] rdata
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  // page register visible on every page; the rest only on the driver page
  always_comb begin
    rdata = 8'h00;
    if (addr == `ODPSR_OFS_PAGE) begin
      rdata = page_img;
    end else if (on_page) begin
      unique case (addr)
        `ODPSR_OFS_AMP_ERR: rdata = amp_img;
        `ODPSR_OFS_HP_DRV: rdata = hp_img;
        `ODPSR_OFS_SPK_DRV: rdata = spk_img;
        default: begin
          if (addr >= `ODPSR_OFS_RSVD_LO && addr <= `ODPSR_OFS_RSVD_HI) begin
            rdata = rsvd_img;
          end
        end
      endcase
    end
  end
endmodule : odpsr_rd_mux
`default_nettype wire

// file: rtl/odpsr_regs.sv
/*
  register bank of the output driver control page: page select, headphone
  and class-d speaker power-up, headphone common mode, short-circuit policy
  and live short status.
  assumes a control-bus front end issuing one-cycle write and read strobes
  synchronous to ref_clk, and short detectors synchronous to ref_clk.
*/
// Functional notes
// - page register at zero takes any 8-bit value and selects later access page
// - speaker policy bit low: speaker short clears both speaker power bits
// - headphone policy low and action power-down: short clears headphone power bits
// - left and right headphone power bits, read-write, reset zero
// - two-bit headphone common-mode field, 1.35 to 1.8 V, resets 00
// - headphone short: limit current if action low, power down if high
// - headphone short status bit read-only, live, resets zero
// - left and right speaker power bits, read-write, reset zero
// - speaker short status bit read-only, valid while speaker powered
`include "odpsr_consts.svh"
`default_nettype none
module odpsr_regs
  import odpsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register access
  input wire odpsr_req_t req,
  output logic [7:0] rdata,
  // short detectors
  input wire logic hp_short,
  input wire logic spk_short,
  // driver controls
  output var odpsr_drv_t drv,
  output logic [7:0] page_sel
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] amp;
    logic [7:0] hp;
    logic [7:0] spk;
    logic [7:0] rsvd;
    logic hp_sts;
    logic spk_sts;
    logic [7:0] rdata;
  } odpsr_state_t;

  odpsr_state_t st_r;
  odpsr_state_t st_nxt;
  logic on_page;
  logic hp_clear;
  logic spk_clear;
  logic hp_limit;
  logic hp_force_off;
  logic [7:0] hp_img;
  logic [7:0] spk_img;
  logic [7:0] rd_val;

  // true when the access falls on the given driver-page offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic pg);
    hit = pg && (a == ofs);
  endfunction : hit

  assign on_page = (st_r.page == `ODPSR_DRIVER_PAGE);

  // ----------------------------------------
  // short policy
  // ----------------------------------------
  odpsr_fault_ctl u_fault (
    .hp_short(hp_short),
    .spk_short(spk_short),
    .hp_action_pd(st_r.hp[`ODPSR_BIT_HP_ACTION]),
    .hp_keep(st_r.amp[`ODPSR_BIT_HP_POLICY]),
    .spk_keep(st_r.amp[`ODPSR_BIT_SPK_POLICY]),
    .hp_limit(hp_limit),
    .hp_force_off(hp_force_off),
    .hp_clear(hp_clear),
    .spk_clear(spk_clear)
  );

  // ----------------------------------------
  // read images: status bit replaces stored bit 0
  // ----------------------------------------
  assign hp_img = {st_r.hp[`ODPSR_BIT_LEFT_PWR:`ODPSR_BIT_STATUS + 1], st_r.hp_sts};
  assign spk_img = {st_r.spk[`ODPSR_BIT_LEFT_PWR:`ODPSR_BIT_STATUS + 1], st_r.spk_sts};

  odpsr_rd_mux u_mux (
    .addr(req.addr),
    .on_page(on_page),
    .page_img(st_r.page),
    .amp_img(st_r.amp),
    .hp_img(hp_img),
    .spk_img(spk_img),
    .rsvd_img(st_r.rsvd),
    .rdata(rd_val)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // the short clear is applied after the write so a fault in the same
  // cycle as a power-up write still wins; the driver must not re-enable
  always_comb begin
    st_nxt = st_r;
    // live status, no effect from writes
    st_nxt.hp_sts = hp_short;
    // speaker flag only meaningful while a class-d side is up
    st_nxt.spk_sts = spk_short & (st_r.spk[`ODPSR_BIT_LEFT_PWR] | st_r.spk[`ODPSR_BIT_RIGHT_PWR]);
    if (req.wr) begin
      if (req.addr == `ODPSR_OFS_PAGE) begin
        st_nxt.page = req.wdata;
      end
      if (hit(req.addr, `ODPSR_OFS_AMP_ERR, on_page)) begin
        st_nxt.amp = req.wdata;
      end
      if (hit(req.addr, `ODPSR_OFS_HP_DRV, on_page)) begin
        st_nxt.hp = req.wdata;
      end
      if (hit(req.addr, `ODPSR_OFS_SPK_DRV, on_page)) begin
        st_nxt.spk = req.wdata;
      end
      // reserved range is a scratch byte; writes are the host's fault
      if (on_page && req.addr >= `ODPSR_OFS_RSVD_LO && req.addr <= `ODPSR_OFS_RSVD_HI) begin
        st_nxt.rsvd = req.wdata;
      end
    end
    if (hp_clear) begin
      st_nxt.hp[`ODPSR_BIT_LEFT_PWR] = 1'b0;
      st_nxt.hp[`ODPSR_BIT_RIGHT_PWR] = 1'b0;
    end
    if (spk_clear) begin
      st_nxt.spk[`ODPSR_BIT_LEFT_PWR] = 1'b0;
      st_nxt.spk[`ODPSR_BIT_RIGHT_PWR] = 1'b0;
    end
    if (req.rd) begin
      st_nxt.rdata = rd_val;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r.page <= `ODPSR_RST_PAGE;
      st_r.amp <= `ODPSR_RST_AMP_ERR;
      st_r.hp <= `ODPSR_RST_HP_DRV;
      st_r.spk <= `ODPSR_RST_SPK_DRV;
      st_r.rsvd <= `ODPSR_RST_RSVD;
      st_r.hp_sts <= 1'b0;
      st_r.spk_sts <= 1'b0;
      st_r.rdata <= `ODPSR_RST_RDATA;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = st_r.rdata;
  assign page_sel = st_r.page;
  // one process drives the whole control struct, so no field has two writers
  always_comb begin
    drv.hp_pwr.left_on = st_r.hp[`ODPSR_BIT_LEFT_PWR];
    drv.hp_pwr.right_on = st_r.hp[`ODPSR_BIT_RIGHT_PWR];
    drv.spk_pwr.left_on = st_r.spk[`ODPSR_BIT_LEFT_PWR];
    drv.spk_pwr.right_on = st_r.spk[`ODPSR_BIT_RIGHT_PWR];
    drv.hp_cm = odpsr_cm_t'(st_r.hp[`ODPSR_CM_HI:`ODPSR_CM_LO]);
    // combinational so protection acts in the detection cycle
    drv.hp_limit = hp_limit;
    drv.hp_force_off = hp_force_off;
  end
endmodule : odpsr_regs
`default_nettype wire

// file: testbench/odpsr_props.sv
/* checker of the odpsr_regs ports: power, policy, status, paging.
   assumes one ref_clk domain with synchronous rst. */
`default_nettype none
module odpsr_props
  import odpsr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // access
  input wire odpsr_req_t req,
  input wire logic [7:0] rdata,
  // detectors and controls
  input wire logic hp_short,
  input wire logic spk_short,
  input wire odpsr_drv_t drv,
  input wire logic [7:0] page_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] keep_r;
  logic act_r;
  logic pg1;
  logic w1f;
  logic w20;
  // ----
  // policy shadow, only page-1 writes land, as the bank does
  // ----
  assign pg1 = page_sel == 8'h01;
  assign w1f = req.wr && pg1 && req.addr == 8'h1f;
  assign w20 = req.wr && pg1 && req.addr == 8'h20;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      keep_r <= 2'h0;
      act_r <= 1'h0;
    end else begin
      if (req.wr && pg1 && req.addr == 8'h1e) keep_r <= req.wdata[1:0];
      if (w1f) act_r <= req.wdata[1];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_page;
    req.wr && req.addr == 8'h00 |=> page_sel == $past(req.wdata);
  endproperty
  a_page: assert property (p_page) else $error("page select not taken");
  property p_spk_clr;
    spk_short && !keep_r[1] |=> drv.spk_pwr == 2'h0;
  endproperty
  a_spk_clr: assert property (p_spk_clr) else $error("speaker power kept on short");
  property p_hp_clr;
    hp_short && !keep_r[0] && act_r |=> drv.hp_pwr == 2'h0;
  endproperty
  a_hp_clr: assert property (p_hp_clr) else $error("headphone power kept on short");
  property p_hp_pwr;
    w1f && !hp_short |=> drv.hp_pwr == $past(req.wdata[7:6]);
  endproperty
  a_hp_pwr: assert property (p_hp_pwr) else $error("headphone power write lost");
  property p_cm;
    w1f |=> drv.hp_cm == $past(req.wdata[4:3]);
  endproperty
  a_cm: assert property (p_cm) else $error("common mode write lost");
  property p_lim;
    hp_short |-> drv.hp_limit != act_r && drv.hp_force_off == act_r;
  endproperty
  a_lim: assert property (p_lim) else $error("short action wrong");
  property p_sts;
    req.rd && pg1 && req.addr == 8'h1f |=> rdata[0] == $past(hp_short, 2);
  endproperty
  a_sts: assert property (p_sts) else $error("headphone status wrong");
  property p_spk_pwr;
    w20 && !spk_short |=> drv.spk_pwr == $past(req.wdata[7:6]);
  endproperty
  a_spk_pwr: assert property (p_spk_pwr) else $error("speaker power write lost");
  property p_gate;
    req.wr && !pg1 && req.addr == 8'h1f && !hp_short |=> $stable(drv.hp_pwr) && $stable(drv.hp_cm);
  endproperty
  a_gate: assert property (p_gate) else $error("write off page landed");
endmodule : odpsr_props
bind odpsr_regs odpsr_props odpsr_props_i (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata),
  .hp_short(hp_short), .spk_short(spk_short), .drv(drv), .page_sel(page_sel));
`default_nettype wire

// file: testbench/odpsr_host.sv
/* host model: one-cycle strobes launched at the falling edge.
   assumes the bench calls its tasks hierarchically. */
`default_nettype none
module odpsr_host
  import odpsr_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // register access
  output var odpsr_req_t req,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // ----
  // accesses; reserved offsets are never written from here
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(negedge ref_clk);
    req.wr = 1'h0;
    req.wdata = ~d; // stale data inverted so a late sample shows
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    req = '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(negedge ref_clk);
    req.rd = 1'h0;
    req.addr = ~a;
    v = rdata;
  endtask : rd
  // reserved fields always carry their mandated pattern
  function automatic logic [7:0] hp_byte(input logic [1:0] p, input logic [1:0] cm, input logic act);
    return {p, 1'h0, cm, 1'h1, act, 1'h0};
  endfunction : hp_byte
  function automatic logic [7:0] spk_byte(input logic [1:0] p);
    return {p, 5'h03, 1'h0};
  endfunction : spk_byte
endmodule : odpsr_host
`default_nettype wire

// file: testbench/tb.sv
/* self-checking bench of odpsr_regs through the host model.
   assumes odpsr_props is bound to the bank. */
`default_nettype none
module tb
  import odpsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic rst;
  logic hp_short;
  logic spk_short;
  odpsr_req_t req;
  odpsr_drv_t drv;
  logic [7:0] rdata;
  logic [7:0] page_sel;
  int mismatches = 0;
  int checks = 0;
  odpsr_regs odpsr_regs_i (.ref_clk(ref_clk), .rst(rst), .req(req), .rdata(rdata), .hp_short(hp_short),
    .spk_short(spk_short), .drv(drv), .page_sel(page_sel));
  odpsr_host odpsr_host_i (.ref_clk(ref_clk), .req(req), .rdata(rdata));
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----
  // compare and report
  // ----
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    odpsr_host_i.rd(a, v);
    chk($sformatf("rdata_%h", a), e, v);
  endtask : rchk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    rst = 1'h1;
    hp_short = 1'h0;
    spk_short = 1'h0;
    repeat (10) @(negedge ref_clk);
    rst = 1'h0;
    rchk(8'h00, 8'h00);
    odpsr_host_i.wr(8'h00, 8'hff);
    chk("page_sel", 8'hff, page_sel);
    rchk(8'h00, 8'hff);
    odpsr_host_i.wr(8'h1f, odpsr_host_i.hp_byte(2'h3, 2'h2, 1'h0));
    rchk(8'h1f, 8'h00);
    odpsr_host_i.wr(8'h00, 8'h01);
    rchk(8'h1e, 8'h00);
    rchk(8'h1f, 8'h04);
    rchk(8'h20, 8'h06);
    $display("test reset_and_paging done");
    for (int c = 0; c < 4; c++) begin
      odpsr_host_i.wr(8'h1f, odpsr_host_i.hp_byte(2'(c), 2'(c), 1'h0));
      chk("hp_cm", 8'(c), 8'(drv.hp_cm));
      chk("hp_pwr", 8'(c), 8'(drv.hp_pwr));
    end
    odpsr_host_i.wr(8'h20, odpsr_host_i.spk_byte(2'h2));
    chk("spk_pwr", 8'h02, 8'(drv.spk_pwr));
    rchk(8'h20, 8'h86);
    $display("test power_fields done");
    // headphone short: power-down action under clearing then keep policy, then limit action
    odpsr_host_i.wr(8'h1f, 8'hc6);
    @(negedge ref_clk);
    hp_short = 1'h1;
    #1;
    chk("hp_force_off", 8'h01, 8'(drv.hp_force_off));
    chk("hp_limit", 8'h00, 8'(drv.hp_limit));
    @(negedge ref_clk);
    chk("hp_pwr", 8'h00, 8'(drv.hp_pwr));
    rchk(8'h1f, 8'h07);
    hp_short = 1'h0;
    odpsr_host_i.wr(8'h1e, 8'h01);
    odpsr_host_i.wr(8'h1f, 8'hc6);
    hp_short = 1'h1;
    @(negedge ref_clk);
    chk("hp_pwr", 8'h03, 8'(drv.hp_pwr));
    odpsr_host_i.wr(8'h1f, 8'hc4);
    chk("hp_limit", 8'h01, 8'(drv.hp_limit));
    hp_short = 1'h0;
    rchk(8'h1f, 8'hc4);
    $display("test headphone_short done");
    // speaker short under both policies
    odpsr_host_i.wr(8'h1e, 8'h00);
    odpsr_host_i.wr(8'h20, odpsr_host_i.spk_byte(2'h3));
    spk_short = 1'h1;
    @(negedge ref_clk);
    chk("spk_pwr", 8'h00, 8'(drv.spk_pwr));
    spk_short = 1'h0;
    odpsr_host_i.wr(8'h1e, 8'h02);
    odpsr_host_i.wr(8'h20, odpsr_host_i.spk_byte(2'h3));
    spk_short = 1'h1;
    @(negedge ref_clk);
    chk("spk_pwr", 8'h03, 8'(drv.spk_pwr));
    rchk(8'h20, 8'hc7);
    // short still present but speaker off: status reads 0
    odpsr_host_i.wr(8'h20, odpsr_host_i.spk_byte(2'h0));
    rchk(8'h20, 8'h06);
    spk_short = 1'h0;
    $display("test speaker_short done");
    // reset in mid-run must drop every stored power bit and the page
    rst = 1'h1;
    repeat (2) @(negedge ref_clk);
    rst = 1'h0;
    chk("hp_pwr", 8'h00, 8'(drv.hp_pwr));
    chk("spk_pwr", 8'h00, 8'(drv.spk_pwr));
    chk("page_sel", 8'h00, page_sel);
    $display("test mid_reset done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
